/* rtl/psaf_status.sv */
`timescale 1ns/1ps
module psaf_status
  import psaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic det_parity_bit,
  input wire logic sig_sys_err_bit,
  input wire logic mst_got_target_abort,
  input wire logic mst_got_master_abort,
  input wire logic mst_active,
  input wire logic mst_drive_perr,
  input wire logic perr_n_pin,
  input wire logic parity_response_enable,
  input wire logic host_xfer_enable,
  output logic mst_inhibit,
  output logic mst_retry,
  input wire logic tgt_valid,
  input wire psaf_pkg::psaf_space_t tgt_space,
  input wire logic tgt_write,
  input wire logic [3:0] tgt_be_n,
  input wire logic [31:0] mem_register_base,
  input wire logic [31:0] rom_base_control,
  input wire logic rom_decode_enable,
  input wire logic serial_prom_access_mode,
  input wire logic power_down,
  input wire logic addr_parity_err,
  input wire logic addr_match,
  output logic tgt_abort,
  output logic serr_assert,
  input wire logic fail_irq_disable,
  input wire logic irq_enable,
  input wire logic clear_pci_error_irq,
  output logic pci_error_flag,
  output logic irq
);
  logic got_target_abort_reg;
  logic got_master_abort_reg;
  logic sent_target_abort_reg;
  logic parity_reported_reg;
  logic pci_error_flag_reg;
  logic tgt_abort_reg;
  logic serr_reg;
  logic [31:0] rdata_reg;
  psaf_state_t state_reg;
  psaf_state_t state_next;
  logic perr_n_sync;
  logic status_wr;
  logic abort_now;
  logic any_err;

  // True when exactly one byte lane is enabled (active-low enables)
  function automatic logic one_byte(input logic [3:0] be_n);
    logic [3:0] be;
    be = ~be_n;
    one_byte = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) || (be == 4'h8);
  endfunction

  // Write-one-to-clear of a status bit with set winning over the clear
  function automatic logic w1c_flag(input logic cur, input logic set, input logic clr);
    w1c_flag = set | (cur & ~clr);
  endfunction

  // Error pin comes from the bus, so it is synchronised first
  psaf_sync2 u_perr_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(perr_n_pin),
    .reset_level(1'b1),
    .sync_out(perr_n_sync)
  );

  // Only the upper byte lane holds clearable bits; lane 2 is all fixed
  assign status_wr = cfg_wr && (cfg_addr == PSAF_STATUS_OFFSET)
    && cfg_byte_en[PSAF_LANE_STATUS_HI];

  // Target abort decision for the access presented this cycle
  always_comb begin
    abort_now = 1'b0;
    if (tgt_valid) begin
      if (tgt_be_n != PSAF_BE_NONE_N) begin
        if ((tgt_space == PSAF_SP_DEVICE) && !one_byte(tgt_be_n)) begin
          abort_now = 1'b1;
        end
        if ((tgt_space == PSAF_SP_SEQ_BLOCK) && !one_byte(tgt_be_n)
            && !(tgt_write && (tgt_be_n == PSAF_BE_ALL_N))) begin
          abort_now = 1'b1;
        end
        if ((tgt_space == PSAF_SP_ROM) && tgt_write && !one_byte(tgt_be_n)) begin
          abort_now = 1'b1;
        end
      end
      if (rom_decode_enable && (mem_register_base == rom_base_control)
          && (tgt_space != PSAF_SP_CONFIG)) begin
        abort_now = 1'b1;
      end
      if (serial_prom_access_mode
          && ((tgt_space == PSAF_SP_SEQ_BLOCK) || (tgt_space == PSAF_SP_ROM))) begin
        abort_now = 1'b1;
      end
      if (power_down && (tgt_space != PSAF_SP_HOST_ONLY)
          && (tgt_space != PSAF_SP_CONFIG)) begin
        abort_now = 1'b1;
      end
      if (addr_parity_err && addr_match) begin
        abort_now = 1'b1;
      end
    end
  end

  // Registered abort and system error strobes, one cycle after the access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_abort_reg <= PSAF_FLAG_RESET;
      serr_reg <= PSAF_FLAG_RESET;
    end else begin
      tgt_abort_reg <= abort_now;
      serr_reg <= tgt_valid && addr_parity_err && addr_match;
    end
  end

  // Abort and parity flags; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got_target_abort_reg <= PSAF_FLAG_RESET;
      got_master_abort_reg <= PSAF_FLAG_RESET;
      sent_target_abort_reg <= PSAF_FLAG_RESET;
      parity_reported_reg <= PSAF_FLAG_RESET;
    end else begin
      got_target_abort_reg <= w1c_flag(got_target_abort_reg, mst_got_target_abort,
        status_wr && cfg_wdata[PSAF_BIT_GOT_TA]);
      got_master_abort_reg <= w1c_flag(got_master_abort_reg, mst_got_master_abort,
        status_wr && cfg_wdata[PSAF_BIT_GOT_MA]);
      sent_target_abort_reg <= w1c_flag(sent_target_abort_reg, tgt_abort_reg,
        status_wr && cfg_wdata[PSAF_BIT_SENT_TA]);
      parity_reported_reg <= w1c_flag(parity_reported_reg,
        mst_active && parity_response_enable && (!perr_n_sync || mst_drive_perr),
        status_wr && cfg_wdata[PSAF_BIT_PARITY_REP]);
    end
  end

  // Error summary of bits 30 to 27 and 24; bit 31 alone raises nothing
  assign any_err = sig_sys_err_bit | got_master_abort_reg
    | got_target_abort_reg | sent_target_abort_reg | parity_reported_reg;

  // Sticky until the error clear; clearing the status bits alone does not drop it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_error_flag_reg <= PSAF_FLAG_RESET;
    end else begin
      pci_error_flag_reg <= w1c_flag(pci_error_flag_reg,
        any_err && irq_enable && !fail_irq_disable && !power_down,
        clear_pci_error_irq);
    end
  end

  // Halt masters after an abort; retry only if still enabled at the clear
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSAF_ST_RUN: begin
        if (mst_got_target_abort || mst_got_master_abort) begin
          state_next = PSAF_ST_HALT;
        end
      end
      PSAF_ST_HALT: begin
        if (!got_target_abort_reg && !got_master_abort_reg
            && !mst_got_target_abort && !mst_got_master_abort) begin
          state_next = host_xfer_enable ? PSAF_ST_RETRY : PSAF_ST_RUN;
        end
      end
      PSAF_ST_RETRY: begin
        state_next = PSAF_ST_RUN;
      end
      default: begin
        state_next = PSAF_ST_RUN;
      end
    endcase
  end

  // Master abort state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PSAF_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read data registered; other offsets read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= PSAF_RDATA_RESET;
    end else if (cfg_rd) begin
      rdata_reg <= PSAF_RDATA_RESET;
      if (cfg_addr == PSAF_STATUS_OFFSET) begin
        rdata_reg[PSAF_BIT_DET_PARITY] <= det_parity_bit;
        rdata_reg[PSAF_BIT_SIG_SYS_ERR] <= sig_sys_err_bit;
        rdata_reg[PSAF_BIT_GOT_MA] <= got_master_abort_reg;
        rdata_reg[PSAF_BIT_GOT_TA] <= got_target_abort_reg;
        rdata_reg[PSAF_BIT_SENT_TA] <= sent_target_abort_reg;
        rdata_reg[PSAF_BIT_DST_HI:PSAF_BIT_DST_LO] <= PSAF_DST_VALUE;
        rdata_reg[PSAF_BIT_PARITY_REP] <= parity_reported_reg;
        rdata_reg[PSAF_BIT_FAST_B2B] <= PSAF_FAST_B2B_VALUE;
      end
    end
  end

  assign cfg_rdata = rdata_reg;
  assign tgt_abort = tgt_abort_reg;
  assign serr_assert = serr_reg;
  assign mst_inhibit = (state_reg == PSAF_ST_HALT);
  assign mst_retry = (state_reg == PSAF_ST_RETRY);
  assign pci_error_flag = pci_error_flag_reg;
  assign irq = pci_error_flag_reg;

  // Received abort is recorded on the next edge
  got_ta_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    mst_got_target_abort |=> got_target_abort_reg)
    else $error("received target abort not recorded");

  // Writing one clears the flag when no new event arrives
  got_ta_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (status_wr && cfg_wdata[PSAF_BIT_GOT_TA] && !mst_got_target_abort)
      |=> !got_target_abort_reg)
    else $error("target abort flag not cleared by write one");

  // Halted master never retries while a flag remains set
  halt_no_retry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (got_target_abort_reg || got_master_abort_reg) |-> !mst_retry)
    else $error("retry while abort flag set");

  // Retry follows the clear only with transfers enabled
  retry_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mst_inhibit && !got_target_abort_reg && !got_master_abort_reg
      && !mst_got_target_abort && !mst_got_master_abort)
      |=> (mst_retry == $past(host_xfer_enable)))
    else $error("retry decision wrong at flag clear");

  // Interrupt stays until the error clear
  irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (irq && !clear_pci_error_irq) |=> irq)
    else $error("interrupt dropped without error clear");

  // Power-down aborts device accesses one cycle later
  pd_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tgt_valid && power_down && (tgt_space == PSAF_SP_DEVICE)) |=> tgt_abort)
    else $error("power-down access not aborted");

  // Address parity error gives abort with system error, then the flag
  ape_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tgt_valid && addr_parity_err && addr_match)
      |=> (tgt_abort && serr_assert) ##1 sent_target_abort_reg)
    else $error("address parity abort missing");

  // Empty config access with no other cause never aborts
  empty_be_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tgt_valid && (tgt_be_n == PSAF_BE_NONE_N) && (tgt_space == PSAF_SP_CONFIG)
      && !addr_parity_err) |=> !tgt_abort)
    else $error("empty data phase aborted");

  // Fixed bits read back constant on a status read
  fixed_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_rd && (cfg_addr == PSAF_STATUS_OFFSET))
      |=> (cfg_rdata[26:25] == PSAF_DST_VALUE) && cfg_rdata[23] && (cfg_rdata[22:16] == 7'h00))
    else $error("fixed status bits wrong");

  // Terminating as target records the flag on the next edge
  sent_ta_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    tgt_abort |=> sent_target_abort_reg)
    else $error("signalled target abort not recorded");

  // Own parity error as master with response enabled is recorded
  par_rep_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mst_active && parity_response_enable && mst_drive_perr) |=> parity_reported_reg)
    else $error("parity report not recorded");

  // A zero written to a set flag leaves it set
  wr_zero_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (got_target_abort_reg && status_wr && !cfg_wdata[PSAF_BIT_GOT_TA])
      |=> got_target_abort_reg)
    else $error("status write stored a zero");

  // Any enabled error bit raises the interrupt on the next edge
  err_irq_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((sig_sys_err_bit || got_master_abort_reg || got_target_abort_reg
      || sent_target_abort_reg || parity_reported_reg)
      && irq_enable && !fail_irq_disable && !power_down) |=> irq)
    else $error("error bit did not raise interrupt");
endmodule

/* rtl/psaf_pkg.sv */
package psaf_pkg;
  // Configuration register offset of the command/status word
  localparam logic [7:0] PSAF_STATUS_OFFSET = 8'h04;
  // Status field positions inside the 32-bit configuration word
  localparam int PSAF_BIT_DET_PARITY = 31;
  localparam int PSAF_BIT_SIG_SYS_ERR = 30;
  localparam int PSAF_BIT_GOT_MA = 29;
  localparam int PSAF_BIT_GOT_TA = 28;
  localparam int PSAF_BIT_SENT_TA = 27;
  localparam int PSAF_BIT_DST_HI = 26;
  localparam int PSAF_BIT_DST_LO = 25;
  localparam int PSAF_BIT_PARITY_REP = 24;
  localparam int PSAF_BIT_FAST_B2B = 23;
  // Byte lanes of the status half
  localparam int PSAF_LANE_STATUS_HI = 3;
  // Device select timing encodings
  localparam logic [1:0] PSAF_DST_FAST = 2'h0;
  localparam logic [1:0] PSAF_DST_MEDIUM = 2'h1;
  localparam logic [1:0] PSAF_DST_SLOW = 2'h2;
  localparam logic [1:0] PSAF_DST_RSVD = 2'h3;
  localparam logic [1:0] PSAF_DST_VALUE = PSAF_DST_MEDIUM;
  localparam logic PSAF_FAST_B2B_VALUE = 1'b1;
  // Values after reset and active-low byte enable patterns
  localparam logic PSAF_FLAG_RESET = 1'b0;
  localparam logic [31:0] PSAF_RDATA_RESET = 32'h0000_0000;
  localparam logic [3:0] PSAF_BE_NONE_N = 4'hf;
  localparam logic [3:0] PSAF_BE_ALL_N = 4'h0;
  // Synchroniser depth for pins
  localparam int PSAF_SYNC_STAGES = 2;

  // Address space of a decoded target access
  typedef enum logic [2:0] {
    PSAF_SP_CONFIG = 3'h0,
    PSAF_SP_HOST_ONLY = 3'h1,
    PSAF_SP_DEVICE = 3'h2,
    PSAF_SP_SEQ_BLOCK = 3'h3,
    PSAF_SP_ROM = 3'h4
  } psaf_space_t;

  // Master abort handling states
  typedef enum logic [2:0] {
    PSAF_ST_RUN = 3'b001,
    PSAF_ST_HALT = 3'b010,
    PSAF_ST_RETRY = 3'b100
  } psaf_state_t;
endpackage

/* rtl/psaf_sync2.sv */
`timescale 1ns/1ps
module psaf_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  input wire logic reset_level,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;

  // Two flops; the first is seen by nothing but the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // Reset level has no effect; both flops reset high whatever it is
  assign sync_out = sync_reg & (reset_level | 1'b1);
endmodule

/* dv/psaf_far_agent.sv */
`timescale 1ns/1ps
// Far side: targets that abort the master, agents on the parity line
module psaf_far_agent (
  input wire logic clk,
  output logic mst_got_target_abort,
  output logic mst_got_master_abort,
  output logic perr_n_pin
);
  // Quiet bus, parity line sits at its pull-up
  initial begin
    mst_got_target_abort = 1'b0;
    mst_got_master_abort = 1'b0;
    perr_n_pin = 1'b1;
  end
  // One-cycle abort answer to the pending master transfer
  task automatic abort_xfer(input bit by_target);
    if (by_target) mst_got_target_abort = 1'b1;
    else mst_got_master_abort = 1'b1;
    @(posedge clk);
    #1;
    // Drop only the line raised, so a following call may raise the other
    if (by_target) mst_got_target_abort = 1'b0;
    else mst_got_master_abort = 1'b0;
  endtask
  // Parity error reported, then line released back to the pull-up
  task automatic report_perr(input int cycles);
    perr_n_pin = 1'b0;
    repeat (cycles) @(posedge clk);
    #1;
    perr_n_pin = 1'b1;
  endtask
endmodule

/* dv/tb_psaf_status.sv */
`timescale 1ns/1ps
module tb_psaf_status;
  import psaf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_rd, cfg_wr, det_parity_bit, sig_sys_err_bit, mst_active, mst_drive_perr;
  logic parity_response_enable, host_xfer_enable, tgt_valid, tgt_write, rom_decode_enable;
  logic serial_prom_access_mode, power_down, addr_parity_err, addr_match, fail_irq_disable;
  logic irq_enable, clear_pci_error_irq, mst_got_target_abort, mst_got_master_abort;
  logic perr_n_pin, mst_inhibit, mst_retry, tgt_abort, serr_assert, pci_error_flag, irq;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en, tgt_be_n;
  logic [31:0] cfg_wdata, cfg_rdata, mem_register_base, rom_base_control;
  psaf_space_t tgt_space;
  psaf_space_t sp_tab[4] = '{PSAF_SP_DEVICE, PSAF_SP_ROM, PSAF_SP_CONFIG, PSAF_SP_HOST_ONLY};
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  bit [31:0] m_flags = 32'h0;
  bit [31:0] seed = 32'ha9ed3ec1;
  bit [31:0] r;

  // Free-running clock
  always #5 clk = ~clk;

  psaf_status u_psaf_status (.clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .det_parity_bit(det_parity_bit), .sig_sys_err_bit(sig_sys_err_bit),
    .mst_got_target_abort(mst_got_target_abort), .mst_got_master_abort(mst_got_master_abort),
    .mst_active(mst_active), .mst_drive_perr(mst_drive_perr), .perr_n_pin(perr_n_pin),
    .parity_response_enable(parity_response_enable), .host_xfer_enable(host_xfer_enable),
    .mst_inhibit(mst_inhibit), .mst_retry(mst_retry), .tgt_valid(tgt_valid),
    .tgt_space(tgt_space), .tgt_write(tgt_write), .tgt_be_n(tgt_be_n),
    .mem_register_base(mem_register_base), .rom_base_control(rom_base_control),
    .rom_decode_enable(rom_decode_enable), .serial_prom_access_mode(serial_prom_access_mode),
    .power_down(power_down), .addr_parity_err(addr_parity_err), .addr_match(addr_match),
    .tgt_abort(tgt_abort), .serr_assert(serr_assert), .fail_irq_disable(fail_irq_disable),
    .irq_enable(irq_enable), .clear_pci_error_irq(clear_pci_error_irq),
    .pci_error_flag(pci_error_flag), .irq(irq));

  psaf_far_agent u_psaf_far_agent (.clk(clk), .mst_got_target_abort(mst_got_target_abort),
    .mst_got_master_abort(mst_got_master_abort), .perr_n_pin(perr_n_pin));

  // Hang guard, far above the roughly 160 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected status word from the flag model and the fixed fields
  function automatic logic [31:0] exp_word();
    logic [31:0] w;
    w = m_flags;
    w[PSAF_BIT_DET_PARITY] = det_parity_bit;
    w[PSAF_BIT_SIG_SYS_ERR] = sig_sys_err_bit;
    w[PSAF_BIT_DST_HI:PSAF_BIT_DST_LO] = PSAF_DST_MEDIUM;
    w[PSAF_BIT_FAST_B2B] = 1'b1;
    return w;
  endfunction

  // Abort decision for one target access; empty enables are never a width fault
  function automatic logic abort_of(psaf_space_t sp, logic wr, logic [3:0] be_n);
    logic bad;
    bad = be_n != 4'hf && $countones(~be_n) != 1;
    return (sp == PSAF_SP_DEVICE && bad) || (sp == PSAF_SP_ROM && wr && bad)
      || (sp == PSAF_SP_SEQ_BLOCK && bad && !(wr && be_n == 4'h0))
      || (rom_decode_enable && mem_register_base == rom_base_control && sp != PSAF_SP_CONFIG)
      || (serial_prom_access_mode && (sp == PSAF_SP_SEQ_BLOCK || sp == PSAF_SP_ROM))
      || (power_down && sp != PSAF_SP_CONFIG && sp != PSAF_SP_HOST_ONLY)
      || (addr_parity_err && addr_match);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Extra edge first so flags set by the last event are in the register
  task automatic rd_status();
    tick();
    cfg_rd = 1'b1;
    cfg_addr = PSAF_STATUS_OFFSET;
    tick();
    cfg_rd = 1'b0;
    chk("status", exp_word(), cfg_rdata);
  endtask

  task automatic wr_status(input logic [31:0] d, input logic [3:0] be);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    cfg_byte_en = be;
    cfg_addr = PSAF_STATUS_OFFSET;
    tick();
    cfg_wr = 1'b0;
    if (be[PSAF_LANE_STATUS_HI]) m_flags &= ~(d & 32'h3900_0000);
  endtask

  task automatic access(input psaf_space_t sp, input logic wr, input logic [3:0] be_n);
    logic ab;
    ab = abort_of(sp, wr, be_n);
    tgt_valid = 1'b1;
    tgt_space = sp;
    tgt_write = wr;
    tgt_be_n = be_n;
    tick();
    tgt_valid = 1'b0;
    chk("abort", 32'(ab), 32'(tgt_abort));
    chk("serr", 32'(addr_parity_err & addr_match), 32'(serr_assert));
    if (ab) m_flags[PSAF_BIT_SENT_TA] = 1'b1;
    // Idle edge so the next access does not re-raise valid in this step
    tick();
  endtask

  // Count retry pulses over a short window after a clear
  task automatic retry_window(input int n);
    int seen;
    seen = 0;
    repeat (4) begin
      if (mst_retry === 1'b1) seen++;
      tick();
    end
    chk("retries", 32'(n), 32'(seen));
  endtask

  task automatic pulse_irq_clear();
    clear_pci_error_irq = 1'b1;
    tick();
    clear_pci_error_irq = 1'b0;
    tick();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    {cfg_rd, cfg_wr, det_parity_bit, sig_sys_err_bit, mst_active, mst_drive_perr} = '0;
    {tgt_valid, tgt_write, rom_decode_enable, serial_prom_access_mode, power_down} = '0;
    {addr_parity_err, addr_match, fail_irq_disable, clear_pci_error_irq} = '0;
    {parity_response_enable, host_xfer_enable, irq_enable} = 3'b111;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
    tgt_be_n = 4'hf;
    tgt_space = PSAF_SP_CONFIG;
    mem_register_base = 32'h0000_1000;
    rom_base_control = 32'h0000_2000;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_status();
    $display("test reset values done");
    u_psaf_far_agent.abort_xfer(1'b1);
    m_flags[PSAF_BIT_GOT_TA] = 1'b1;
    chk("inhibit", 32'h1, 32'(mst_inhibit));
    u_psaf_far_agent.abort_xfer(1'b0);
    m_flags[PSAF_BIT_GOT_MA] = 1'b1;
    repeat (3) tick();
    chk("error flag", 32'h1, 32'(pci_error_flag));
    chk("irq", 32'h1, 32'(irq));
    rd_status();
    wr_status(32'hffff_ffff, 4'h7);
    rd_status();
    wr_status(32'h1000_0000, 4'h8);
    retry_window(0);
    rd_status();
    wr_status(32'h2000_0000, 4'h8);
    retry_window(1);
    chk("inhibit", 32'h0, 32'(mst_inhibit));
    chk("error flag", 32'h1, 32'(pci_error_flag));
    pulse_irq_clear();
    chk("error flag", 32'h0, 32'(pci_error_flag));
    $display("test master aborts done");
    irq_enable = 1'b0;
    host_xfer_enable = 1'b0;
    u_psaf_far_agent.abort_xfer(1'b1);
    m_flags[PSAF_BIT_GOT_TA] = 1'b1;
    wr_status(32'h1000_0000, 4'h8);
    retry_window(0);
    chk("error flag", 32'h0, 32'(pci_error_flag));
    {irq_enable, host_xfer_enable} = 2'b11;
    $display("test retry disabled done");
    repeat (40) begin
      r = xs();
      power_down = r[8] & r[9];
      serial_prom_access_mode = r[10] & r[11];
      rom_base_control = r[12] ? mem_register_base : 32'h0000_2000;
      rom_decode_enable = r[13];
      addr_parity_err = r[14] & r[15];
      addr_match = r[16];
      access(sp_tab[r[1:0]], r[2], r[6:3]);
    end
    {power_down, rom_decode_enable, addr_parity_err, addr_match} = '0;
    serial_prom_access_mode = 1'b0;
    access(PSAF_SP_DEVICE, 1'b1, 4'hf);
    access(PSAF_SP_SEQ_BLOCK, 1'b1, 4'h0);
    access(PSAF_SP_SEQ_BLOCK, 1'b0, 4'h0);
    serial_prom_access_mode = 1'b1;
    access(PSAF_SP_SEQ_BLOCK, 1'b0, 4'he);
    serial_prom_access_mode = 1'b0;
    rd_status();
    wr_status(32'h0800_0000, 4'h8);
    rd_status();
    $display("test target aborts done");
    mst_active = 1'b1;
    parity_response_enable = 1'b0;
    mst_drive_perr = 1'b1;
    tick();
    mst_drive_perr = 1'b0;
    rd_status();
    parity_response_enable = 1'b1;
    mst_drive_perr = 1'b1;
    tick();
    mst_drive_perr = 1'b0;
    m_flags[PSAF_BIT_PARITY_REP] = 1'b1;
    rd_status();
    wr_status(32'h0100_0000, 4'h8);
    u_psaf_far_agent.report_perr(3);
    m_flags[PSAF_BIT_PARITY_REP] = 1'b1;
    repeat (3) tick();
    {det_parity_bit, sig_sys_err_bit} = 2'b11;
    rd_status();
    mst_active = 1'b0;
    $display("test parity report done");
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    {det_parity_bit, sig_sys_err_bit} = 2'b00;
    m_flags = 32'h0;
    rd_status();
    det_parity_bit = 1'b1;
    repeat (2) tick();
    chk("error flag", 32'h0, 32'(pci_error_flag));
    {det_parity_bit, sig_sys_err_bit} = 2'b01;
    repeat (2) tick();
    chk("irq", 32'h1, 32'(irq));
    $display("test second reset done");
    complete_run();
  end
endmodule
